// *** dv/core_map_chk.sv ***
// assertions on the status flags and the access answers
`timescale 1ns/10ps
module core_map_chk (
    input wire logic                   mclk_i, reset_i, mem_re_i, mem_we_i,
    input wire logic                   sleep_i, wdt_clear_i, wdt_timeout_i,
    input wire logic                   rvalid_o, sfr_re_o,
    input wire logic [6:0]             mem_offset_i,
    input wire logic [7:0]             opa_i, opb_i, status_o,
    input wire core_map_pkg::alu_op_t  alu_op_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // operands kept one cycle so flag checks see the sum that caused them
    logic [8:0] sum_ff, dif_ff;
    logic       nib_ff, add, sub, peripheral_register_area;
    assign add = mem_we_i && alu_op_i == core_map_pkg::ALU_ADD;
    assign sub = mem_we_i && alu_op_i == core_map_pkg::ALU_SUB;
    assign peripheral_register_area = mem_offset_i >= 7'h0C && mem_offset_i <= 7'h1F;
    always_ff @(posedge mclk_i) begin
        sum_ff <= {1'b0, opa_i} + {1'b0, opb_i};
        dif_ff <= {1'b0, opa_i} + {1'b0, ~opb_i} + 9'h001;
        nib_ff <= ({1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]}) > 5'h0F;
    end
    a_status_top_zero: assert property (status_o[7:5] == 3'h0)
        else $error("status upper bits not zero");
    a_timeout_clears: assert property (wdt_timeout_i |=> !status_o[4])
        else $error("expiry flag kept after time-out");
    a_sleep_clears_pd: assert property (sleep_i |=> !status_o[3])
        else $error("power-down flag kept after sleep");
    a_reset_flags_held: assert property (!(sleep_i || wdt_clear_i || wdt_timeout_i)
        |=> $stable(status_o[4:3])) else $error("reset-cause flags moved");
    a_add_flags_exact: assert property (add |=> status_o[1:0] == {nib_ff, sum_ff[8]}
        && status_o[2] == (sum_ff[7:0] == 8'h00)) else $error("add flags wrong");
    a_sub_no_borrow: assert property (sub |=> status_o[0] == dif_ff[8])
        else $error("subtract carry wrong");
    a_clear_status_pattern: assert property (mem_we_i && mem_offset_i == 7'h03
        && alu_op_i == core_map_pkg::ALU_CLEAR
        |=> status_o[2:0] == {1'b1, $past(status_o[1:0])}) else $error("clear wrong");
    a_read_one_cycle: assert property (mem_re_i && !peripheral_register_area && !sfr_re_o |=> rvalid_o)
        else $error("read answer late");
    a_sfr_read_order: assert property (mem_re_i && peripheral_register_area && !sfr_re_o
        |=> sfr_re_o ##1 rvalid_o) else $error("peripheral read order wrong");
    c_sub: cover property (sub);
    c_sfr_read: cover property (mem_re_i && peripheral_register_area);
    c_sleep: cover property (sleep_i);
endmodule

bind core_status_and_bank_map core_map_chk core_map_chk_i (.mclk_i, .reset_i, .mem_re_i,
    .mem_we_i, .sleep_i, .wdt_clear_i, .wdt_timeout_i, .rvalid_o, .sfr_re_o, .mem_offset_i,
    .opa_i, .opb_i, .status_o, .alu_op_i);

// *** dv/core_status_and_bank_map_bench.sv ***
// self-checking bench for the core registers, flags and bank map
`timescale 1ns/10ps
module core_status_and_bank_map_bench;
    localparam core_map_pkg::alu_op_t PS = core_map_pkg::ALU_PASS;
    localparam core_map_pkg::alu_op_t AD = core_map_pkg::ALU_ADD;
    localparam core_map_pkg::alu_op_t SB = core_map_pkg::ALU_SUB;
    localparam core_map_pkg::alu_op_t CL = core_map_pkg::ALU_CLEAR;
    localparam core_map_pkg::alu_op_t AN = core_map_pkg::ALU_AND;
    localparam core_map_pkg::alu_op_t ORR = core_map_pkg::ALU_OR;
    localparam core_map_pkg::alu_op_t XR = core_map_pkg::ALU_XOR;
    logic mclk_i = 0, reset_i = 1, mem_re_i = 0, mem_we_i = 0;
    logic sleep_i = 0, wdt_clear_i = 0, wdt_timeout_i = 0, rvalid_o, sfr_we_o, sfr_re_o;
    logic [6:0] mem_offset_i = 7'h00;
    logic [7:0] opa_i = 8'h00, opb_i = 8'h00, sfr_rdata_i = 8'h6B, rdata_o, alu_result_o;
    logic [7:0] status_o, bank_select_o, working_o, pc_latch_o, interrupt_control_o, sfr_wdata_o;
    logic [11:0] sfr_addr_o;
    core_map_pkg::alu_op_t alu_op_i = core_map_pkg::ALU_PASS;
    int fails = 0, samples_checked = 0, cycles = 0;
    // two ram banks keep the unmapped-bank case close at hand
    core_status_and_bank_map #(.GPR_BANKS(2)) core_status_and_bank_map_i (.mclk_i, .reset_i,
        .mem_re_i, .mem_we_i, .mem_offset_i, .alu_op_i, .opa_i, .opb_i, .sleep_i, .wdt_clear_i,
        .wdt_timeout_i, .sfr_rdata_i, .rdata_o, .rvalid_o, .alu_result_o, .status_o,
        .bank_select_o, .working_o, .pc_latch_o, .interrupt_control_o, .sfr_we_o, .sfr_re_o,
        .sfr_addr_o, .sfr_wdata_o);
    always #20 mclk_i = ~mclk_i;
    // ****
    // shared drivers and compare
    // ****
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write per call; outputs are looked at 1 ns after the taking edge
    task automatic wr(input logic [6:0] off, input core_map_pkg::alu_op_t op,
                      input logic [7:0] a, input logic [7:0] b);
        @(posedge mclk_i);
        mem_we_i     <= 1'b1;
        mem_offset_i <= off;
        alu_op_i     <= op;
        opa_i        <= a;
        opb_i        <= b;
        @(posedge mclk_i);
        mem_we_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [6:0] off, input logic [7:0] exp);
        int n;
        @(posedge mclk_i);
        mem_re_i     <= 1'b1;
        mem_offset_i <= off;
        @(posedge mclk_i);
        mem_re_i <= 1'b0;
        n = 0;
        #1;
        while (rvalid_o !== 1'b1 && n < 4) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk(rvalid_o === 1'b1 ? rdata_o : ~exp, exp);
    endtask
    // events go out as {time-out, watchdog clear, sleep}
    task automatic ev(input logic [2:0] e, input logic [7:0] exp);
        @(posedge mclk_i);
        {wdt_timeout_i, wdt_clear_i, sleep_i} <= e;
        @(posedge mclk_i);
        {wdt_timeout_i, wdt_clear_i, sleep_i} <= 3'h0;
        #1;
        chk(status_o, exp);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_banks;
        wr(7'h08, PS, 8'h00, 8'hFF);
        chk(bank_select_o, 8'h1F);
        wr(7'h08, PS, 8'h00, 8'h01);
        wr(7'h20, PS, 8'h00, 8'h77);
        wr(7'h70, PS, 8'h00, 8'hA5);
        wr(7'h09, PS, 8'h00, 8'h3C);
        chk(working_o, 8'h3C);
        wr(7'h08, PS, 8'h00, 8'h05);
        rd(7'h70, 8'hA5);
        rd(7'h09, 8'h3C);
        rd(7'h20, 8'h00);
        wr(7'h05, PS, 8'h00, 8'h20);
        wr(7'h04, PS, 8'h00, 8'h50);
        rd(7'h00, 8'h77);
        rd(7'h0C, 8'h6B);
        wr(7'h0D, PS, 8'h00, 8'h11);
        chk({3'h0, sfr_addr_o[11:7]}, 8'h05);
        chk({1'b0, sfr_addr_o[6:0]}, 8'h0D);
        chk(sfr_wdata_o, 8'h11);
        chk({7'h00, sfr_we_o}, 8'h01);
    endtask
    // logic ops set zero only; carry pair is kept from before
    task automatic t_logic;
        wr(7'h0A, ORR, 8'h30, 8'h03);
        chk(pc_latch_o, 8'h33);
        chk(alu_result_o, 8'h33);
        chk(status_o, 8'h01);
        wr(7'h0B, AN, 8'hF0, 8'h3C);
        chk(interrupt_control_o, 8'h30);
        wr(7'h0B, XR, 8'h5A, 8'h5A);
        chk(status_o, 8'h05);
    endtask
    // a second reset in mid-run brings the reset-cause pair back to one
    task automatic t_reset;
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        chk(status_o, 8'h18);
        chk(bank_select_o, 8'h00);
    endtask
    task automatic t_flags;
        wr(7'h09, AD, 8'hF8, 8'h08);
        chk(status_o, 8'h1F);
        wr(7'h09, SB, 8'h05, 8'h03);
        chk(status_o, 8'h1B);
        wr(7'h09, SB, 8'h03, 8'h05);
        chk(status_o, 8'h18);
        wr(7'h03, AD, 8'h0F, 8'h01);
        chk(status_o, 8'h1A);
        wr(7'h03, CL, 8'h00, 8'h00);
        chk(status_o, 8'h1E);
        wr(7'h03, PS, 8'h00, 8'hE1);
        chk(status_o, 8'h19);
    endtask
    // hang guard, far above the roughly eighty cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        chk(status_o, 8'h18);
        t_banks();
        t_flags();
        ev(3'h1, 8'h11);
        ev(3'h4, 8'h01);
        ev(3'h2, 8'h19);
        ev(3'h7, 8'h01);
        t_logic();
        t_reset();
        report_and_stop();
    end
endmodule

// *** shared/core_map_pkg.sv ***
// shared constants and types for the core register file and bank map
package core_map_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 12;
    localparam int OFS_W     = 7;
    localparam int BANK_W    = 5;
    localparam int PTR_W     = 16;
    localparam int LIN_W     = 13;
    localparam int NIBBLE_W  = 4;
    localparam int NUM_BANKS = 32;

    // ************************************************************
    // core register offsets inside every bank
    // ************************************************************
    localparam logic [6:0] OFS_INDIRECT0   = 7'h00;
    localparam logic [6:0] OFS_INDIRECT1   = 7'h01;
    localparam logic [6:0] OFS_PCL         = 7'h02;
    localparam logic [6:0] OFS_STATUS      = 7'h03;
    localparam logic [6:0] OFS_PTR0_LOW    = 7'h04;
    localparam logic [6:0] OFS_PTR0_HIGH   = 7'h05;
    localparam logic [6:0] OFS_PTR1_LOW    = 7'h06;
    localparam logic [6:0] OFS_PTR1_HIGH   = 7'h07;
    localparam logic [6:0] OFS_BANK_SELECT = 7'h08;
    localparam logic [6:0] OFS_WORKING     = 7'h09;
    localparam logic [6:0] OFS_PC_LATCH    = 7'h0A;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL      = 7'h0B;
    localparam int         CORE_FIRST      = 2;
    localparam int         CORE_LAST       = 11;

    // ************************************************************
    // bank areas
    // ************************************************************
    localparam logic [6:0] SFR_FIRST    = 7'h0C;
    localparam logic [6:0] SFR_LAST     = 7'h1F;
    localparam logic [6:0] GPR_FIRST    = 7'h20;
    localparam logic [6:0] GPR_LAST     = 7'h6F;
    localparam logic [6:0] COMMON_FIRST = 7'h70;
    localparam int         GPR_BYTES    = 80;
    localparam int         COMMON_BYTES = 16;
    localparam int         GPR_BANKS    = 12;

    // ************************************************************
    // pointer decoding
    // ************************************************************
    localparam int         PTR_FLASH_BIT = 15;
    localparam logic [2:0] LINEAR_TAG    = 3'h1;

    // ************************************************************
    // status layout and reset values
    // ************************************************************
    localparam int         ST_C  = 0;
    localparam int         ST_DC = 1;
    localparam int         ST_Z  = 2;
    localparam int         ST_PD = 3;
    localparam int         ST_TO = 4;
    localparam logic [7:0] STATUS_RESET    = 8'h18;
    localparam logic [7:0] STATUS_IMPL     = 8'h1F;
    localparam logic [7:0] BANK_SEL_MASK   = 8'h1F;
    localparam logic [7:0] CORE_RESET      = 8'h00;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ALU_PASS  = 3'b000,
        ALU_ADD   = 3'b001,
        ALU_SUB   = 3'b010,
        ALU_AND   = 3'b011,
        ALU_OR    = 3'b100,
        ALU_XOR   = 3'b101,
        ALU_CLEAR = 3'b110
    } alu_op_t;

    typedef enum logic [1:0] {
        REG_CORE = 2'b00,
        REG_SFR  = 2'b01,
        REG_RAM  = 2'b10,
        REG_NONE = 2'b11
    } region_t;

endpackage

// *** src/core_status_and_bank_map.sv ***
// core registers, status flags and data memory bank map of an 8-bit core
`timescale 1ns/10ps

module core_status_and_bank_map #(
    parameter int GPR_BANKS = core_map_pkg::GPR_BANKS
) (
    // clock and reset
    input  wire logic                                mclk_i,
    input  wire logic                                reset_i,
    // data memory access from the instruction sequencer
    input  wire logic                                mem_re_i,
    input  wire logic                                mem_we_i,
    input  wire logic [core_map_pkg::OFS_W-1:0]      mem_offset_i,
    input  wire core_map_pkg::alu_op_t               alu_op_i,
    input  wire logic [core_map_pkg::DATA_W-1:0]     opa_i,
    input  wire logic [core_map_pkg::DATA_W-1:0]     opb_i,
    // hardware reset-cause events
    input  wire logic                                sleep_i,
    input  wire logic                                wdt_clear_i,
    input  wire logic                                wdt_timeout_i,
    // peripheral register area read data
    input  wire logic [core_map_pkg::DATA_W-1:0]     sfr_rdata_i,
    // read answer
    output logic      [core_map_pkg::DATA_W-1:0]     rdata_o,
    output logic                                     rvalid_o,
    output logic      [core_map_pkg::DATA_W-1:0]     alu_result_o,
    // core state
    output logic      [core_map_pkg::DATA_W-1:0]     status_o,
    output logic      [core_map_pkg::DATA_W-1:0]     bank_select_o,
    output logic      [core_map_pkg::DATA_W-1:0]     working_o,
    output logic      [core_map_pkg::DATA_W-1:0]     pc_latch_o,
    output logic      [core_map_pkg::DATA_W-1:0]     interrupt_control_o,
    // peripheral register area strobes
    output logic                                     sfr_we_o,
    output logic                                     sfr_re_o,
    output logic      [core_map_pkg::ADDR_W-1:0]     sfr_addr_o,
    output logic      [core_map_pkg::DATA_W-1:0]     sfr_wdata_o
);

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int RAM_WORDS = GPR_BANKS * core_map_pkg::GPR_BYTES + core_map_pkg::COMMON_BYTES;
    localparam int AW        = $clog2(RAM_WORDS);
    localparam logic [core_map_pkg::LIN_W-1:0] GPR_TOTAL =
        core_map_pkg::LIN_W'(GPR_BANKS * core_map_pkg::GPR_BYTES);
    localparam logic [core_map_pkg::LIN_W-1:0] GPR_STEP  =
        core_map_pkg::LIN_W'(core_map_pkg::GPR_BYTES);

    // ************************************************************
    // offset decoding
    // ************************************************************
    // sort one bank-relative offset into its area
    function automatic core_map_pkg::region_t region_of(
        input logic [core_map_pkg::OFS_W-1:0]  ofs,
        input logic [core_map_pkg::BANK_W-1:0] bank
    );
        core_map_pkg::region_t r;
        if (ofs < core_map_pkg::OFS_PCL) begin
            r = core_map_pkg::REG_NONE;            // indirect port seen through a pointer
        end else if (ofs <= core_map_pkg::OFS_INTERRUPT_CONTROL) begin
            r = core_map_pkg::REG_CORE;
        end else if (ofs <= core_map_pkg::SFR_LAST) begin
            r = core_map_pkg::REG_SFR;
        end else if (ofs <= core_map_pkg::GPR_LAST) begin
            r = (int'(bank) < GPR_BANKS) ? core_map_pkg::REG_RAM : core_map_pkg::REG_NONE;
        end else begin
            r = core_map_pkg::REG_RAM;
        end
        return r;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [core_map_pkg::DATA_W-1:0] core_ff     [core_map_pkg::CORE_FIRST:core_map_pkg::CORE_LAST];
    logic [core_map_pkg::DATA_W-1:0] nxt_core    [core_map_pkg::CORE_FIRST:core_map_pkg::CORE_LAST];
    logic [core_map_pkg::DATA_W-1:0] rdata_ff;
    logic [core_map_pkg::DATA_W-1:0] nxt_rdata;
    logic                            rvalid_ff;
    logic                            nxt_rvalid;
    logic                            sfr_pend_ff;
    logic                            nxt_sfr_pend;
    logic [core_map_pkg::DATA_W-1:0] alu_ff;
    logic [core_map_pkg::DATA_W-1:0] nxt_alu;
    logic                            sfr_we_ff;
    logic                            nxt_sfr_we;
    logic                            sfr_re_ff;
    logic                            nxt_sfr_re;
    logic [core_map_pkg::ADDR_W-1:0] sfr_addr_ff;
    logic [core_map_pkg::ADDR_W-1:0] nxt_sfr_addr;
    logic [core_map_pkg::DATA_W-1:0] sfr_wdata_ff;
    logic [core_map_pkg::DATA_W-1:0] nxt_sfr_wdata;

    // ************************************************************
    // address resolution
    // ************************************************************
    logic [core_map_pkg::PTR_W-1:0]  ptr;
    logic [core_map_pkg::ADDR_W-1:0] eff_addr;
    logic [core_map_pkg::OFS_W-1:0]  loff;
    logic [core_map_pkg::BANK_W-1:0] lbank;
    logic [core_map_pkg::LIN_W-1:0]  lin_idx;
    logic [core_map_pkg::LIN_W-1:0]  ram_idx;
    logic                            lin_hit;
    logic                            flash_hit;
    core_map_pkg::region_t           region;

    // the two indirect ports borrow the address from their pointer pair
    always_comb begin
        ptr       = (mem_offset_i == core_map_pkg::OFS_INDIRECT1) ?
                    {core_ff[core_map_pkg::OFS_PTR1_HIGH], core_ff[core_map_pkg::OFS_PTR1_LOW]} :
                    {core_ff[core_map_pkg::OFS_PTR0_HIGH], core_ff[core_map_pkg::OFS_PTR0_LOW]};
        eff_addr  = {core_ff[core_map_pkg::OFS_BANK_SELECT][core_map_pkg::BANK_W-1:0],
                     mem_offset_i};
        lin_hit   = 1'b0;
        flash_hit = 1'b0;
        lin_idx   = ptr[core_map_pkg::LIN_W-1:0];
        if (mem_offset_i <= core_map_pkg::OFS_INDIRECT1) begin
            if (ptr[core_map_pkg::PTR_FLASH_BIT]) begin
                flash_hit = 1'b1;      // program flash is not data memory here, reads zero
            end else if (ptr[core_map_pkg::PTR_W-1:core_map_pkg::LIN_W] ==
                         core_map_pkg::LINEAR_TAG) begin
                lin_hit = 1'b1;
            end else begin
                eff_addr = ptr[core_map_pkg::ADDR_W-1:0];
            end
        end
        loff  = eff_addr[core_map_pkg::OFS_W-1:0];
        lbank = eff_addr[core_map_pkg::ADDR_W-1:core_map_pkg::OFS_W];
        if (flash_hit) begin
            region = core_map_pkg::REG_NONE;
        end else if (lin_hit) begin
            region = (lin_idx < GPR_TOTAL) ? core_map_pkg::REG_RAM : core_map_pkg::REG_NONE;
        end else begin
            region = region_of(loff, lbank);
        end
        // linear index and banked index share one layout, so no division is needed
        if (lin_hit) begin
            ram_idx = lin_idx;
        end else if (loff >= core_map_pkg::COMMON_FIRST) begin
            ram_idx = GPR_TOTAL + core_map_pkg::LIN_W'(loff - core_map_pkg::COMMON_FIRST);
        end else begin
            ram_idx = core_map_pkg::LIN_W'(lbank) * GPR_STEP +
                      core_map_pkg::LIN_W'(loff - core_map_pkg::GPR_FIRST);
        end
    end

    // ************************************************************
    // alu and flags
    // ************************************************************
    logic [core_map_pkg::DATA_W-1:0]   b_eff;
    logic [core_map_pkg::DATA_W:0]     sum9;
    logic [core_map_pkg::NIBBLE_W:0]   nib5;
    logic [core_map_pkg::DATA_W-1:0]   result;
    logic                              arith;
    logic                              sets_z;

    // subtraction is a + ~b + 1, so carries come out as inverted borrows
    always_comb begin
        arith  = (alu_op_i == core_map_pkg::ALU_ADD) || (alu_op_i == core_map_pkg::ALU_SUB);
        b_eff  = (alu_op_i == core_map_pkg::ALU_SUB) ? ~opb_i : opb_i;
        sum9   = {1'b0, opa_i} + {1'b0, b_eff} +
                 (core_map_pkg::DATA_W+1)'(alu_op_i == core_map_pkg::ALU_SUB);
        nib5   = {1'b0, opa_i[core_map_pkg::NIBBLE_W-1:0]} +
                 {1'b0, b_eff[core_map_pkg::NIBBLE_W-1:0]} +
                 (core_map_pkg::NIBBLE_W+1)'(alu_op_i == core_map_pkg::ALU_SUB);
        sets_z = (alu_op_i != core_map_pkg::ALU_PASS);
        case (alu_op_i)
            core_map_pkg::ALU_ADD:   result = sum9[core_map_pkg::DATA_W-1:0];
            core_map_pkg::ALU_SUB:   result = sum9[core_map_pkg::DATA_W-1:0];
            core_map_pkg::ALU_AND:   result = opa_i & opb_i;
            core_map_pkg::ALU_OR:    result = opa_i | opb_i;
            core_map_pkg::ALU_XOR:   result = opa_i ^ opb_i;
            core_map_pkg::ALU_CLEAR: result = core_map_pkg::READ_ZERO;
            default:                 result = opb_i;    // pass covers moves and swaps
        endcase
    end

    // ************************************************************
    // core registers and status
    // ************************************************************
    logic core_we;
    logic [core_map_pkg::DATA_W-1:0] st;

    always_comb begin
        core_we = mem_we_i && (region == core_map_pkg::REG_CORE);
        for (int i = core_map_pkg::CORE_FIRST; i <= core_map_pkg::CORE_LAST; i++) begin
            nxt_core[i] = core_ff[i];
            if (core_we && (int'(loff) == i) && (loff != core_map_pkg::OFS_STATUS)) begin
                nxt_core[i] = result;
            end
        end
        // only five bank bits exist, the rest read zero
        nxt_core[core_map_pkg::OFS_BANK_SELECT] =
            nxt_core[core_map_pkg::OFS_BANK_SELECT] & core_map_pkg::BANK_SEL_MASK;
        st = core_ff[core_map_pkg::OFS_STATUS];
        if (core_we && (loff == core_map_pkg::OFS_STATUS) && !sets_z) begin
            // plain moves reach the arithmetic flags only, never the reset-cause pair
            st[core_map_pkg::ST_Z]  = result[core_map_pkg::ST_Z];
            st[core_map_pkg::ST_DC] = result[core_map_pkg::ST_DC];
            st[core_map_pkg::ST_C]  = result[core_map_pkg::ST_C];
        end
        if (mem_we_i && sets_z) begin
            // a flag-updating instruction overrides its own write to status
            st[core_map_pkg::ST_Z] = (result == core_map_pkg::READ_ZERO);
            if (arith) begin
                st[core_map_pkg::ST_DC] = nib5[core_map_pkg::NIBBLE_W];
                st[core_map_pkg::ST_C]  = sum9[core_map_pkg::DATA_W];
            end
        end
        if (wdt_clear_i) begin
            st[core_map_pkg::ST_TO] = 1'b1;
            st[core_map_pkg::ST_PD] = 1'b1;
        end
        if (sleep_i) begin
            st[core_map_pkg::ST_TO] = 1'b1;
            st[core_map_pkg::ST_PD] = 1'b0;
        end
        if (wdt_timeout_i) begin
            st[core_map_pkg::ST_TO] = 1'b0;
        end
        nxt_core[core_map_pkg::OFS_STATUS] = st & core_map_pkg::STATUS_IMPL;
    end

    always_ff @(posedge mclk_i) begin
        for (int i = core_map_pkg::CORE_FIRST; i <= core_map_pkg::CORE_LAST; i++) begin
            if (reset_i) begin
                core_ff[i] <= (i == int'(core_map_pkg::OFS_STATUS)) ?
                              core_map_pkg::STATUS_RESET : core_map_pkg::CORE_RESET;
            end else begin
                core_ff[i] <= nxt_core[i];
            end
        end
    end

    // ************************************************************
    // general and common ram
    // ************************************************************
    logic [core_map_pkg::DATA_W-1:0] ram_rdata;

    general_ram #(
        .WORDS (RAM_WORDS),
        .AW    (AW),
        .DW    (core_map_pkg::DATA_W)
    ) u_ram (
        .mclk_i  (mclk_i),
        .we_i    (mem_we_i && (region == core_map_pkg::REG_RAM)),
        .waddr_i (ram_idx[AW-1:0]),
        .wdata_i (result),
        .raddr_i (ram_idx[AW-1:0]),
        .rdata_o (ram_rdata)
    );

    // ************************************************************
    // read path and peripheral strobes
    // ************************************************************
    // a peripheral read answers one cycle late; a read offered then is ignored
    always_comb begin
        nxt_rdata     = rdata_ff;
        nxt_rvalid    = 1'b0;
        nxt_sfr_pend  = 1'b0;
        nxt_sfr_re    = 1'b0;
        nxt_sfr_we    = mem_we_i && (region == core_map_pkg::REG_SFR);
        nxt_sfr_addr  = sfr_addr_ff;
        nxt_sfr_wdata = sfr_wdata_ff;
        nxt_alu       = mem_we_i ? result : alu_ff;
        if (nxt_sfr_we) begin
            nxt_sfr_addr  = eff_addr;
            nxt_sfr_wdata = result;
        end
        if (sfr_pend_ff) begin
            nxt_rdata  = sfr_rdata_i;
            nxt_rvalid = 1'b1;
        end else if (mem_re_i) begin
            nxt_rvalid = 1'b1;
            case (region)
                core_map_pkg::REG_CORE: nxt_rdata = core_ff[loff];
                core_map_pkg::REG_RAM:  nxt_rdata = ram_rdata;
                core_map_pkg::REG_SFR: begin
                    nxt_rvalid   = 1'b0;
                    nxt_sfr_pend = 1'b1;
                    nxt_sfr_re   = 1'b1;
                    nxt_sfr_addr = eff_addr;
                end
                default:                nxt_rdata = core_map_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_ff     <= core_map_pkg::READ_ZERO;
            rvalid_ff    <= 1'b0;
            sfr_pend_ff  <= 1'b0;
            alu_ff       <= core_map_pkg::READ_ZERO;
            sfr_we_ff    <= 1'b0;
            sfr_re_ff    <= 1'b0;
            sfr_addr_ff  <= '0;
            sfr_wdata_ff <= core_map_pkg::READ_ZERO;
        end else begin
            rdata_ff     <= nxt_rdata;
            rvalid_ff    <= nxt_rvalid;
            sfr_pend_ff  <= nxt_sfr_pend;
            alu_ff       <= nxt_alu;
            sfr_we_ff    <= nxt_sfr_we;
            sfr_re_ff    <= nxt_sfr_re;
            sfr_addr_ff  <= nxt_sfr_addr;
            sfr_wdata_ff <= nxt_sfr_wdata;
        end
    end

    // ************************************************************
    // outputs, all straight from flip-flops
    // ************************************************************
    assign rdata_o       = rdata_ff;
    assign rvalid_o      = rvalid_ff;
    assign alu_result_o  = alu_ff;
    assign status_o      = core_ff[core_map_pkg::OFS_STATUS];
    assign bank_select_o = core_ff[core_map_pkg::OFS_BANK_SELECT];
    assign working_o     = core_ff[core_map_pkg::OFS_WORKING];
    assign pc_latch_o    = core_ff[core_map_pkg::OFS_PC_LATCH];
    assign interrupt_control_o      = core_ff[core_map_pkg::OFS_INTERRUPT_CONTROL];
    assign sfr_we_o      = sfr_we_ff;
    assign sfr_re_o      = sfr_re_ff;
    assign sfr_addr_o    = sfr_addr_ff;
    assign sfr_wdata_o   = sfr_wdata_ff;

endmodule

// *** src/general_ram.sv ***
// banked general purpose and common ram storage
`timescale 1ns/10ps

module general_ram #(
    parameter int WORDS = 976,
    parameter int AW    = 10,
    parameter int DW    = 8
) (
    // clock
    input  wire logic          mclk_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // read port, combinational so the owner can register it
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:WORDS-1];

    // contents are not reset, like any ram
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // out of range index reads zero instead of an unknown
    always_comb begin
        rdata_o = '0;
        if (int'(raddr_i) < WORDS) begin
            rdata_o = mem[raddr_i];
        end
    end

endmodule
